// [psbs_seq.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - After the last word of a defined-length read, wait stays deasserted while select stays low.
// - Past the end of a defined-length read the bus keeps driving words of no meaning.
// - A row crossing holds wait for the latency code, or code plus one in variable latency when a refresh is due.
// - A burst write begins with wait held for exactly the latency code in cycles.
// - A falling address-valid during a fixed-latency read begins a new access at once.
// - The first read word arrives latency code plus one clocks after the address.
module psbs_seq (
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  input  wire logic                     clk_en_in,
  input  wire logic [15:0]              bus_config_reg_in,
  output logic                          powerup_done_out,
  output logic                          select_overrun_out,
  input  wire logic                     mem_clk_in,
  input  wire psbs_pkg::psbs_ctl_t      ctl_in,
  input  wire logic [psbs_pkg::DATA_W-1:0] ad_in,
  output logic      [psbs_pkg::DATA_W-1:0] ad_out,
  output logic                          ad_oe_out,
  output logic                          wait_n_out,
  output logic                          wait_oe_out
);

  // ---------------- Main clock domain ----------------
  logic [psbs_pkg::PU_W-1:0]  pu_cnt_ff;
  logic [psbs_pkg::CEM_W-1:0] low_cnt_ff;
  logic [1:0]                 cs_sync_ff;
  logic                       refresh_due_ff;
  logic [15:0]                cfg_ff;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pu_cnt_ff        <= '0;
      powerup_done_out <= 1'h0;
    end else if (clk_en_in && !powerup_done_out) begin
      if (pu_cnt_ff == psbs_pkg::PU_W'(psbs_pkg::PU_CYCLES - 1)) begin
        powerup_done_out <= 1'h1;
      end
      pu_cnt_ff <= pu_cnt_ff + 1'h1;
    end
  end

  // Config is treated as static while accesses run; a plain resync is enough
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cfg_ff <= psbs_pkg::CFG_RESET;
    end else if (clk_en_in) begin
      cfg_ff <= bus_config_reg_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cs_sync_ff <= 2'h3;
    end else if (clk_en_in) begin
      cs_sync_ff <= {cs_sync_ff[0], ctl_in.chip_sel_n};
    end
  end

  // Select held low too long: flag the overrun and ask for a refresh slot
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      low_cnt_ff         <= '0;
      refresh_due_ff     <= 1'h0;
      select_overrun_out <= 1'h0;
    end else if (clk_en_in) begin
      if (cs_sync_ff[1]) begin
        low_cnt_ff     <= '0;
        refresh_due_ff <= 1'h0;
      end else begin
        if (low_cnt_ff != psbs_pkg::CEM_W'(psbs_pkg::CEM_CYCLES)) begin
          low_cnt_ff <= low_cnt_ff + 1'h1;
        end else begin
          select_overrun_out <= 1'h1;
        end
        if (low_cnt_ff == psbs_pkg::CEM_W'(psbs_pkg::REF_CYCLES)) begin
          refresh_due_ff <= 1'h1;
        end
      end
    end
  end

  // ---------------- Link clock domain ----------------
  localparam int SW = 20;
  logic [SW-1:0]         ls1_ff;
  logic [SW-1:0]         ls2_ff;
  logic                  lrst_n;
  logic                  len;
  logic                  up_l;
  logic                  ref_l;
  psbs_pkg::psbs_cfg_t   cfg_l;

  always_ff @(posedge mem_clk_in) begin
    ls1_ff <= {nrst_in, clk_en_in, powerup_done_out, refresh_due_ff, cfg_ff};
    ls2_ff <= ls1_ff;
  end

  assign lrst_n = ls2_ff[19];
  assign len    = ls2_ff[18];
  assign up_l   = ls2_ff[17];
  assign ref_l  = ls2_ff[16];
  assign cfg_l  = psbs_pkg::psbs_cfg_t'(ls2_ff[15:0]);

  psbs_pkg::psbs_state_t           state_ff;
  psbs_pkg::psbs_state_t           nxt_state;
  logic [psbs_pkg::CNT_W-1:0]      cnt_ff;
  logic [psbs_pkg::CNT_W-1:0]      nxt_cnt;
  logic [psbs_pkg::MEM_AW-1:0]     addr_ff;
  logic [psbs_pkg::MEM_AW-1:0]     nxt_addr;
  logic [psbs_pkg::MEM_AW-1:0]     mask;
  logic [psbs_pkg::MEM_AW-1:0]     inc;
  logic [psbs_pkg::MEM_AW-1:0]     rd_addr;
  logic [psbs_pkg::WORDS_W-1:0]    words_ff;
  logic [psbs_pkg::WORDS_W-1:0]    blen;
  logic [psbs_pkg::CNT_W-1:0]      lc_eff;
  logic                            dir_wr_ff;
  logic                            start;
  logic                            wrapping;
  logic                            last_word;
  logic                            row_end;
  logic                            wait_cur;
  logic                            wait_nxt;

  always_comb begin
    unique case (cfg_l.burst_len)
      psbs_pkg::BL_4:  blen = psbs_pkg::WORDS_W'(4);
      psbs_pkg::BL_8:  blen = psbs_pkg::WORDS_W'(8);
      psbs_pkg::BL_16: blen = psbs_pkg::WORDS_W'(16);
      psbs_pkg::BL_32: blen = psbs_pkg::WORDS_W'(32);
      default:         blen = '0;
    endcase
  end

  // A zero code would mean no delay at all; one cycle is the shortest we keep
  assign lc_eff = (cfg_l.latency_code == 3'h0) ? psbs_pkg::CNT_W'(1)
                                               : psbs_pkg::CNT_W'(cfg_l.latency_code);
  // Accesses only in synchronous mode and after the power-up interval
  assign start     = !ctl_in.chip_sel_n && !ctl_in.address_valid_n && up_l
                     && !cfg_l.operating_mode_bit;
  assign wrapping  = !cfg_l.wrap_off && (blen != '0);
  assign mask      = psbs_pkg::MEM_AW'(blen - 1'h1);
  assign inc       = addr_ff + 1'h1;
  assign nxt_addr  = wrapping ? ((addr_ff & ~mask) | (inc & mask)) : inc;
  assign last_word = (blen != '0) && ((words_ff + 1'h1) == blen);
  assign row_end   = !wrapping && (nxt_addr[psbs_pkg::ROW_BITS-1:0] == '0);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (ctl_in.chip_sel_n) begin
      nxt_state = psbs_pkg::S_IDLE;
    end else if (start) begin
      nxt_state = psbs_pkg::S_LAT;
      nxt_cnt   = lc_eff;
    end else begin
      unique case (state_ff)
        psbs_pkg::S_LAT, psbs_pkg::S_ROW: begin
          if (cnt_ff <= psbs_pkg::CNT_W'(1)) begin
            nxt_state = psbs_pkg::S_DATA;
          end else begin
            nxt_cnt = cnt_ff - 1'h1;
          end
        end
        psbs_pkg::S_DATA: begin
          if (last_word) begin
            nxt_state = psbs_pkg::S_END;
          end else if (row_end) begin
            nxt_state = psbs_pkg::S_ROW;
            nxt_cnt   = lc_eff + psbs_pkg::CNT_W'(!cfg_l.fixed_latency && ref_l);
          end
        end
        default: begin
          nxt_state = state_ff;
        end
      endcase
    end
  end

  always_ff @(posedge mem_clk_in) begin
    if (!lrst_n) begin
      state_ff <= psbs_pkg::S_IDLE;
      cnt_ff   <= '0;
    end else if (len) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge mem_clk_in) begin
    if (!lrst_n) begin
      addr_ff   <= '0;
      words_ff  <= '0;
      dir_wr_ff <= 1'h0;
    end else if (len && !ctl_in.chip_sel_n) begin
      if (start) begin
        addr_ff   <= ad_in[psbs_pkg::MEM_AW-1:0];
        words_ff  <= '0;
        dir_wr_ff <= !ctl_in.write_en_n;
      end else if (state_ff == psbs_pkg::S_DATA) begin
        addr_ff  <= nxt_addr;
        words_ff <= words_ff + 1'h1;
      end
    end
  end

  // Read port tracks the word address so the register always holds the current word
  always_comb begin
    if (start) begin
      rd_addr = ad_in[psbs_pkg::MEM_AW-1:0];
    end else if (state_ff == psbs_pkg::S_DATA && !ctl_in.chip_sel_n) begin
      rd_addr = nxt_addr;
    end else begin
      rd_addr = addr_ff;
    end
  end

  psbs_word_mem #(
    .AW (psbs_pkg::MEM_AW),
    .DW (psbs_pkg::DATA_W)
  ) u_mem (
    .clk_in    (mem_clk_in),
    .en_in     (len && lrst_n),
    .wr_in     (dir_wr_ff && state_ff == psbs_pkg::S_DATA && !ctl_in.chip_sel_n && !start),
    .waddr_in  (addr_ff),
    .wdata_in  (ad_in),
    .raddr_in  (rd_addr),
    .rdata_out (ad_out)
  );

  assign wait_cur = (state_ff == psbs_pkg::S_LAT) || (state_ff == psbs_pkg::S_ROW);
  assign wait_nxt = (nxt_state == psbs_pkg::S_LAT) || (nxt_state == psbs_pkg::S_ROW);
  // Timing bit set moves wait one clock ahead of the delay
  assign wait_n_out  = !(cfg_l.wait_timing_bit ? wait_nxt : wait_cur);
  assign wait_oe_out = !ctl_in.chip_sel_n;
  // Past the burst end the array word at the held address keeps flowing with no meaning attached
  assign ad_oe_out = !dir_wr_ff && !ctl_in.chip_sel_n && !ctl_in.output_en_n
                     && (state_ff == psbs_pkg::S_DATA || state_ff == psbs_pkg::S_END);

  // Helper for the checks: length of each wait run and its kind
  logic [psbs_pkg::CNT_W-1:0] run_ff;
  logic                       row_kind_ff;

  always_ff @(posedge mem_clk_in) begin
    if (!lrst_n) begin
      run_ff      <= '0;
      row_kind_ff <= 1'h0;
    end else if (len) begin
      run_ff      <= wait_nxt ? run_ff + 1'h1 : '0;
      row_kind_ff <= (nxt_state == psbs_pkg::S_ROW) ||
                     (row_kind_ff && nxt_state != psbs_pkg::S_LAT);
    end
  end

  a_end_no_wait: assert property (@(posedge mem_clk_in) disable iff (!lrst_n || !len)
    (state_ff == psbs_pkg::S_END && !ctl_in.chip_sel_n && !start) |-> wait_n_out)
    else $error("wait asserted after burst end");
  a_end_drive: assert property (@(posedge mem_clk_in) disable iff (!lrst_n || !len)
    (state_ff == psbs_pkg::S_END && !dir_wr_ff && !ctl_in.chip_sel_n
     && !ctl_in.output_en_n) |-> ad_oe_out)
    else $error("bus not driven past burst end");
  a_row_wait_len: assert property (@(posedge mem_clk_in) disable iff (!lrst_n || !len)
    ($rose(state_ff == psbs_pkg::S_DATA) && $past(state_ff) == psbs_pkg::S_ROW) |->
    (cfg_l.fixed_latency ? ($past(run_ff) == lc_eff)
      : ($past(run_ff) == lc_eff || $past(run_ff) == lc_eff + psbs_pkg::CNT_W'(1))))
    else $error("row crossing wait length wrong");
  a_write_wait_len: assert property (@(posedge mem_clk_in) disable iff (!lrst_n || !len)
    (state_ff == psbs_pkg::S_LAT && nxt_state == psbs_pkg::S_DATA && dir_wr_ff)
    |-> (run_ff == lc_eff))
    else $error("write start wait length wrong");
  a_read_latency: assert property (@(posedge mem_clk_in) disable iff (!lrst_n || !len)
    (start && ctl_in.write_en_n && lc_eff == psbs_pkg::CNT_W'(2)
     && !cfg_l.wait_timing_bit) ##1 (!ctl_in.chip_sel_n && !start) [*2]
    |=> state_ff == psbs_pkg::S_DATA && wait_n_out)
    else $error("first read word not at code plus one");
  a_dir_latch: assert property (@(posedge mem_clk_in) disable iff (!lrst_n || !len)
    start |=> (dir_wr_ff == !$past(ctl_in.write_en_n)))
    else $error("burst direction not latched from write enable");
  a_restart_adv: assert property (@(posedge mem_clk_in) disable iff (!lrst_n || !len)
    (start && (state_ff == psbs_pkg::S_DATA || state_ff == psbs_pkg::S_END))
    |=> state_ff == psbs_pkg::S_LAT && words_ff == '0)
    else $error("address valid did not restart access");
  a_gate_powerup: assert property (@(posedge mem_clk_in) disable iff (!lrst_n || !len)
    (!up_l && state_ff == psbs_pkg::S_IDLE) |=> state_ff == psbs_pkg::S_IDLE)
    else $error("access taken before power-up done");
  a_pu_time: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(powerup_done_out) |-> $past(pu_cnt_ff) == psbs_pkg::PU_W'(psbs_pkg::PU_CYCLES - 1))
    else $error("power-up interval length wrong");
  a_overrun_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (clk_en_in && !cs_sync_ff[1] && low_cnt_ff == psbs_pkg::CEM_W'(psbs_pkg::CEM_CYCLES))
    |=> select_overrun_out)
    else $error("select overrun not flagged");

endmodule
`default_nettype wire

// [psbs_pkg.sv]
package psbs_pkg;

  // Main clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PU_TIME_US    = 150;
  localparam int PU_CYCLES     = (PU_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PU_W          = 12;
  localparam int CEM_TIME_NS   = 4000;
  localparam int CEM_CYCLES    = CEM_TIME_NS / CLK_PERIOD_NS;
  localparam int REF_TIME_NS   = 2000;
  localparam int REF_CYCLES    = REF_TIME_NS / CLK_PERIOD_NS;
  localparam int CEM_W         = 8;

  // Bus and array geometry
  localparam int DATA_W    = 16;
  localparam int MEM_AW    = 8;
  localparam int ROW_BITS  = 7;
  localparam int CNT_W     = 4;
  localparam int WORDS_W   = 6;

  localparam logic [15:0] CFG_RESET = 16'h8D1F;

  // Burst length codes
  localparam logic [2:0] BL_4  = 3'h1;
  localparam logic [2:0] BL_8  = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [2:0] BL_32 = 3'h4;

  // Bit positions: 15 mode, 14 latency kind, 13:11 code, 8 wait timing, 3 wrap off, 2:0 length
  typedef struct packed {
    logic       operating_mode_bit;
    logic       fixed_latency;
    logic [2:0] latency_code;
    logic [1:0] rsv_hi;
    logic       wait_timing_bit;
    logic [3:0] rsv_mid;
    logic       wrap_off;
    logic [2:0] burst_len;
  } psbs_cfg_t;

  typedef struct packed {
    logic chip_sel_n;
    logic address_valid_n;
    logic write_en_n;
    logic output_en_n;
  } psbs_ctl_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_LAT,
    S_DATA,
    S_ROW,
    S_END
  } psbs_state_t;

endpackage

// [psbs_word_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module psbs_word_mem #(
  parameter int AW = psbs_pkg::MEM_AW,
  parameter int DW = psbs_pkg::DATA_W
) (
  input  wire logic          clk_in,
  input  wire logic          en_in,
  input  wire logic          wr_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem_ff [0:(1<<AW)-1];

  always_ff @(posedge clk_in) begin
    if (en_in && wr_in) begin
      mem_ff[waddr_in] <= wdata_in;
    end
  end

  // Read data from a register so the pad sees a clean flop output
  always_ff @(posedge clk_in) begin
    if (en_in) begin
      rdata_out <= mem_ff[raddr_in];
    end
  end

endmodule
`default_nettype wire

// [psbs_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psbs_ctrl_model (
  output logic                    mem_clk_out,
  output psbs_pkg::psbs_ctl_t     ctl_out,
  output logic             [15:0] ad_out,
  input  wire logic        [15:0] ad_in,
  input  wire logic               ad_oe_in,
  input  wire logic               wait_n_in
);
  logic [15:0] wbuf [0:63];
  logic [15:0] rbuf [0:63];
  int          wlow;
  int          wext;
  int          oe_bad;
  initial begin
    mem_clk_out = 1'h0;
    ctl_out = 4'hF;
    ad_out = 16'h0000;
  end
  // Clock runs only while tick is called, idle ticks with select high included; 125 ns period
  task automatic tick(output logic w, output logic [15:0] d, output logic o);
    #62.5;
    w = wait_n_in;
    d = ad_in;
    o = ad_oe_in;
    mem_clk_out = 1'h1;
    #62.5;
    mem_clk_out = 1'h0;
  endtask
  task automatic idle(input int n);
    logic        w;
    logic [15:0] d;
    logic        o;
    ctl_out = 4'hF;
    repeat (n) tick(w, d, o);
  endtask
  task automatic xfer(input logic rd, input logic [7:0] a, input int n, input int ext,
                      input logic keep);
    logic        w;
    logic [15:0] d;
    logic        o;
    int          k;
    int          g;
    wlow = 0;
    wext = 0;
    oe_bad = 0;
    k = 0;
    g = 0;
    ctl_out = '{chip_sel_n: 1'h0, address_valid_n: 1'h0, write_en_n: rd,
                output_en_n: 1'h1};
    ad_out = {8'h00, a};
    tick(w, d, o);
    ctl_out.address_valid_n = 1'h1;
    ctl_out.output_en_n = !rd;
    // Released bus shows the inverse, never the stale address
    ad_out = ~ad_out;
    while (k < n && g < 80) begin
      if (!rd && wait_n_in) ad_out = wbuf[k];
      tick(w, d, o);
      g++;
      if (!w) wlow++;
      else begin
        if (rd) rbuf[k] = d;
        if (rd && !o) oe_bad++;
        k++;
      end
    end
    if (!rd) ad_out = ~ad_out;
    // Words past a defined burst are taken but never used
    repeat (ext) begin
      tick(w, d, o);
      if (!w) wext++;
    end
    if (!keep) begin
      ctl_out = 4'hF;
      tick(w, d, o);
    end
  endtask
endmodule
`default_nettype wire

// [psbs_seq_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module psbs_seq_bench;
  logic                clk_in;
  logic                nrst_in;
  logic                clk_en_in;
  logic         [15:0] cfg;
  logic                pu_done;
  logic                overrun;
  logic                mclk;
  psbs_pkg::psbs_ctl_t ctl;
  logic         [15:0] to_dev;
  logic         [15:0] from_dev;
  logic                ad_oe;
  logic                wait_n;
  logic                wait_oe;
  int                  errors;
  int                  n_checks;
  int                  cyc;
  int                  r0;
  psbs_seq uut (.clk_in(clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
    .bus_config_reg_in(cfg), .powerup_done_out(pu_done), .select_overrun_out(overrun),
    .mem_clk_in(mclk), .ctl_in(ctl), .ad_in(to_dev), .ad_out(from_dev),
    .ad_oe_out(ad_oe), .wait_n_out(wait_n), .wait_oe_out(wait_oe));
  psbs_ctrl_model u_ctrl (.mem_clk_out(mclk), .ctl_out(ctl), .ad_out(to_dev),
    .ad_in(from_dev), .ad_oe_in(ad_oe), .wait_n_in(wait_n));
  initial clk_in = 1'h0;
  always #25 clk_in = ~clk_in;
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Ceiling well above power-up plus all bursts
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] pat(input int a);
    return 16'hC300 + 16'(a);
  endfunction
  task automatic setcfg(input logic [2:0] lc, input logic fx, input logic wo,
                        input logic [2:0] bl, input logic am);
    psbs_pkg::psbs_cfg_t c;
    c = '0;
    c.operating_mode_bit = am;
    c.fixed_latency = fx;
    c.latency_code = lc;
    c.wrap_off = wo;
    c.burst_len = bl;
    @(negedge clk_in);
    cfg = c;
    // Two idle burst clocks so the new setting reaches the link side before a start
    u_ctrl.idle(2);
  endtask
  task automatic rdchk(input int base, input int n);
    for (int i = 0; i < n; i++) chk("read word", pat(base + i), u_ctrl.rbuf[i]);
  endtask
  initial begin
    nrst_in = 1'h0;
    clk_en_in = 1'h1;
    cfg = psbs_pkg::CFG_RESET;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    // Two burst-clock edges inside reset; the idle clocks of setcfg finish the link reset
    fork
      u_ctrl.idle(2);
      repeat (5) @(negedge clk_in);
    join
    nrst_in = 1'h1;
    r0 = cyc;
    chk("powerup reset", 16'h0000, {15'h0000, pu_done});
    chk("overrun reset", 16'h0000, {15'h0000, overrun});
    chk("wait reset", 16'h0001, {15'h0000, wait_n});
    chk("wait enable idle", 16'h0000, {15'h0000, wait_oe});
    setcfg(3'h2, 1'h1, 1'h0, psbs_pkg::BL_4, 1'h0);
    u_ctrl.xfer(1'h1, 8'h05, 1, 0, 1'h0);
    chk("early start", 16'h0000, 16'(u_ctrl.wlow));
    // A frozen clock enable stretches the power-up count by the frozen cycles
    @(negedge clk_in);
    clk_en_in = 1'h0;
    repeat (10) @(negedge clk_in);
    clk_en_in = 1'h1;
    while (cyc < r0 + 3000) @(negedge clk_in);
    chk("powerup early", 16'h0000, {15'h0000, pu_done});
    while (cyc < r0 + 3020) @(negedge clk_in);
    chk("powerup late", 16'h0001, {15'h0000, pu_done});
    u_ctrl.idle(2);
    for (int lc = 1; lc <= 4; lc++) begin
      for (int fx = 0; fx < 2; fx++) begin
        setcfg(3'(lc), fx[0], 1'h0, psbs_pkg::BL_4, 1'h0);
        for (int i = 0; i < 4; i++) u_ctrl.wbuf[i] = pat(8 * lc + i);
        u_ctrl.xfer(1'h0, 8'(8 * lc), 4, 0, 1'h0);
        chk("write wait", 16'(lc), 16'(u_ctrl.wlow));
      end
    end
    for (int lc = 1; lc <= 4; lc++) begin
      setcfg(3'(lc), 1'h1, 1'h0, psbs_pkg::BL_4, 1'h0);
      u_ctrl.xfer(1'h1, 8'(8 * lc), 4, 2, lc == 4);
      chk("read wait", 16'(lc), 16'(u_ctrl.wlow));
      chk("wait past end", 16'h0000, 16'(u_ctrl.wext));
      chk("read enable", 16'h0000, 16'(u_ctrl.oe_bad));
      rdchk(8 * lc, 4);
      if (lc == 4) chk("wait enable", 16'h0001, {15'h0000, wait_oe});
    end
    // Restart under a held select, past the burst end
    u_ctrl.xfer(1'h1, 8'h09, 2, 0, 1'h0);
    chk("restart wait", 16'h0004, 16'(u_ctrl.wlow));
    rdchk(9, 2);
    setcfg(3'h3, 1'h1, 1'h1, 3'h0, 1'h0);
    for (int i = 0; i < 4; i++) u_ctrl.wbuf[i] = pat(126 + i);
    u_ctrl.xfer(1'h0, 8'h7E, 4, 0, 1'h0);
    chk("row write wait", 16'h0006, 16'(u_ctrl.wlow));
    u_ctrl.xfer(1'h1, 8'h7E, 4, 0, 1'h0);
    chk("row read wait", 16'h0006, 16'(u_ctrl.wlow));
    rdchk(126, 4);
    // Stop at the row end: select rises half a clock after the last word, once the row wait has begun
    u_ctrl.xfer(1'h1, 8'h7E, 2, 0, 1'h0);
    chk("row stop wait", 16'h0003, 16'(u_ctrl.wlow));
    rdchk(126, 2);
    setcfg(3'h3, 1'h0, 1'h1, 3'h0, 1'h0);
    u_ctrl.xfer(1'h1, 8'h7E, 4, 0, 1'h0);
    chk("row var wait", 16'h0001, {15'h0000, u_ctrl.wlow inside {6, 7}});
    rdchk(126, 4);
    setcfg(3'h2, 1'h1, 1'h0, psbs_pkg::BL_4, 1'h1);
    u_ctrl.xfer(1'h1, 8'h08, 1, 0, 1'h0);
    chk("async refused", 16'h0000, 16'(u_ctrl.wlow));
    chk("no overrun", 16'h0000, {15'h0000, overrun});
    // Select held low beyond the limit on purpose
    setcfg(3'h2, 1'h1, 1'h0, 3'h0, 1'h0);
    u_ctrl.xfer(1'h1, 8'h00, 36, 0, 1'h0);
    repeat (4) @(negedge clk_in);
    chk("overrun", 16'h0001, {15'h0000, overrun});
    report_and_stop();
  end
endmodule
`default_nettype wire
